// >>> src/irhc_ctrl.sv
// Receive handshake control slice of a two-wire serial bus interface:
// extended control register, receive-ready flag, SCL hold, interrupt.
// Assumes a single-cycle register port and open-drain SCL/SDA pins.
//
// Function
// - With the stop mask clear, a slave-mode stop sets the irq flag.
// - With the stop mask set, a stop leaves the irq flag untouched.
// - Handshake off: reception continues right after a good byte unless ready is still set.
// - Handshake on: after a good byte with ready clear, SCL is held.
// - In handshake mode a data read releases SCL for the next byte.
// - Ready is set when a byte moves to the buffer at ninth rise.
// - A byte waiting behind a set ready moves in right after a read.
// - Ready clears on data read, enable low or latch-clear code.
// - Direction 1 is transmit, 0 receive; ack reads bus or software.
// - Codes 0101, 0110, 0111 clear channel 0, 1 or both; read as 1.
`timescale 1ns/1ps
`include "irhc_params.svh"

module irhc_ctrl import irhc_pkg::*; #(
   parameter int CHANNEL = 0
) (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [`IRHC_ADDR_W-1:0]  addr,
   input  wire logic [7:0]               wr_data,
   input  wire logic                     wr_stb,
   input  wire logic                     rd_stb,
   output logic      [7:0]               rd_data,
   output logic                          irq,
   input  wire logic                     scl_in,
   output logic                          scl_out,
   output logic                          scl_oe,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       stop_mask_r;
   logic       rx_handshake_select_r;
   logic       rdy_r;
   logic       pend_r;
   logic       hold_r;
   logic [7:0] rx_buf_r;
   logic       en_r;
   logic       mst_r;
   logic       dir_r;
   logic       ack_sw_r;
   logic [2:0] status_r;
   logic [2:0] status_nxt;
   logic [2:0] mask_r;
   logic [7:0] rd_nxt;
   logic       byte_done;
   logic [7:0] shift_data;
   logic       ack_bus;
   logic       stop_det;
   logic       err_stop_det;
   logic       ack_drive;
   logic       clear_now;
   logic       rx_clear;
   logic       rd_data_hit;
   logic       rx_byte;
   logic       ack_rd;

   localparam logic [7:0] EXT_RST = `IRHC_EXT_RST;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(
      input logic [`IRHC_ADDR_W-1:0] a,
      input logic [`IRHC_ADDR_W-1:0] ofs
   );
      hit = (a == ofs);
   endfunction

   function automatic logic clr_match(input logic [3:0] code);
      logic ch0;
      logic ch1;
      ch0 = (code == `IRHC_CLR_CH0) || (code == `IRHC_CLR_BOTH);
      ch1 = (code == `IRHC_CLR_CH1) || (code == `IRHC_CLR_BOTH);
      clr_match = (CHANNEL == 0) ? ch0 : ch1;
   endfunction

   // Latch clear takes effect in the write cycle itself
   assign clear_now = wr_stb && hit(addr, `IRHC_OFS_SWITCH)
                      && clr_match(wr_data[3:0]);
   assign rx_clear  = clear_now || !en_r;
   // Reads in transmit direction neither clear nor transfer
   assign rd_data_hit = rd_stb && hit(addr, `IRHC_OFS_DATA)
                        && !dir_r;
   assign rx_byte   = byte_done && !dir_r;
   assign ack_rd    = dir_r ? ack_bus : ack_sw_r;

   // ****************************************
   // Pin synchronisation and receive shifter
   // ****************************************
   irhc_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({scl_in, sda_in}),
      .sync_out (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   irhc_rx_shift #(
      .DATA_BITS (`IRHC_DATA_BITS)
   ) u_rx (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .clear        (rx_clear),
      .scl_s        (scl_s),
      .sda_s        (sda_s),
      .ack_value    (ack_sw_r),
      .byte_done    (byte_done),
      .shift_data   (shift_data),
      .ack_bus      (ack_bus),
      .stop_det     (stop_det),
      .err_stop_det (err_stop_det),
      .ack_drive    (ack_drive)
   );

   // ****************************************
   // Extended control register
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stop_mask_r <= EXT_RST[`IRHC_EXT_MASK];
         rx_handshake_select_r      <= EXT_RST[`IRHC_EXT_RX_HANDSHAKE_SELECT];
      end else if (wr_stb && hit(addr, `IRHC_OFS_EXT)) begin
         stop_mask_r <= wr_data[`IRHC_EXT_MASK];
         rx_handshake_select_r      <= wr_data[`IRHC_EXT_RX_HANDSHAKE_SELECT];
      end
   end

   // ****************************************
   // Interface control register
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_r     <= 1'b0;
         mst_r    <= 1'b0;
         dir_r    <= 1'b0;
         ack_sw_r <= 1'b0;
      end else if (wr_stb && hit(addr, `IRHC_OFS_CTRL)) begin
         en_r     <= wr_data[`IRHC_CTRL_EN];
         mst_r    <= wr_data[`IRHC_CTRL_MST];
         dir_r    <= wr_data[`IRHC_CTRL_DIR];
         ack_sw_r <= wr_data[`IRHC_CTRL_ACK];
      end
   end

   // ****************************************
   // Receive-ready flag and receive buffer
   // ****************************************
   // Read clear first, set after, so a set in the same cycle wins over a data read; rx_clear wins over both
   always_ff @(posedge clk) begin
      if (sys_rst || rx_clear) begin
         rdy_r  <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         if (rd_data_hit) begin
            rdy_r <= 1'b0;
         end
         if (pend_r && !rdy_r) begin
            pend_r <= 1'b0;
            rdy_r  <= 1'b1;
         end
         if (rx_byte) begin
            if (rdy_r) begin
               pend_r <= 1'b1;
            end else begin
               rdy_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_buf_r <= 8'h00;
      end else if (rx_byte && !rdy_r) begin
         rx_buf_r <= shift_data;
      end else if (pend_r && !rdy_r) begin
         rx_buf_r <= shift_data;
      end
   end

   // ****************************************
   // SCL hold
   // ****************************************
   // A waiting byte also holds SCL: the shifter must not be overrun
   always_ff @(posedge clk) begin
      if (sys_rst || rx_clear) begin
         hold_r <= 1'b0;
      end else if (rx_byte && (rx_handshake_select_r || rdy_r)) begin
         hold_r <= 1'b1;
      end else if (rd_data_hit) begin
         hold_r <= 1'b0;
      end
   end

   // Grab SCL only once the master has pulled it low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_oe  <= 1'b0;
         scl_out <= 1'b0;
      end else begin
         scl_oe  <= hold_r && !rd_data_hit && (scl_oe || !scl_s);
         scl_out <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         sda_oe  <= ack_drive && !dir_r && en_r;
         sda_out <= 1'b0;
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   always_comb begin
      status_nxt = status_r;
      if (wr_stb && hit(addr, `IRHC_OFS_STATUS)) begin
         status_nxt = status_r & ~wr_data[2:0];
      end
      if (!mst_r && (stop_det || err_stop_det) && !stop_mask_r) begin
         status_nxt[`IRHC_ST_IFACE] = 1'b1;
      end
      if (rx_byte) begin
         status_nxt[`IRHC_ST_IFACE] = 1'b1;
      end
      if (stop_det) begin
         status_nxt[`IRHC_ST_STOP] = 1'b1;
      end
      if (err_stop_det) begin
         status_nxt[`IRHC_ST_ERROR_STOP_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_r <= 3'h0;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_r <= `IRHC_MASK_RST;
      end else if (wr_stb && hit(addr, `IRHC_OFS_MASK)) begin
         mask_r <= wr_data[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_nxt & mask_r);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      rd_nxt = 8'h00;
      unique case (addr)
         `IRHC_OFS_EXT: begin
            rd_nxt[`IRHC_EXT_MASK] = stop_mask_r;
            rd_nxt[`IRHC_EXT_RX_HANDSHAKE_SELECT] = rx_handshake_select_r;
            rd_nxt[`IRHC_EXT_RDY]  = rdy_r;
         end
         `IRHC_OFS_DATA: begin
            rd_nxt = rx_buf_r;
         end
         `IRHC_OFS_CTRL: begin
            rd_nxt[`IRHC_CTRL_EN]  = en_r;
            rd_nxt[`IRHC_CTRL_MST] = mst_r;
            rd_nxt[`IRHC_CTRL_DIR] = dir_r;
            rd_nxt[`IRHC_CTRL_ACK] = ack_rd;
         end
         `IRHC_OFS_SWITCH: begin
            rd_nxt = `IRHC_SWITCH_RD;
         end
         `IRHC_OFS_STATUS: begin
            rd_nxt = {5'h00, status_r};
         end
         `IRHC_OFS_MASK: begin
            rd_nxt = {5'h00, mask_r};
         end
         default: begin
            rd_nxt = 8'h00;
         end
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
      end else if (rd_stb) begin
         rd_data <= rd_nxt;
      end else begin
         rd_data <= 8'h00;
      end
   end

endmodule

// >>> src/irhc_params.svh
// Register map, field positions, reset values and codes of the receive
// handshake control slice. Assumes an 8-bit data, 3-bit address port.
`ifndef IRHC_PARAMS_SVH
`define IRHC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define IRHC_ADDR_W      3
`define IRHC_OFS_EXT     3'h0
`define IRHC_OFS_DATA    3'h1
`define IRHC_OFS_CTRL    3'h2
`define IRHC_OFS_SWITCH  3'h3
`define IRHC_OFS_STATUS  3'h4
`define IRHC_OFS_MASK    3'h5

// ****************************************
// Field positions
// ****************************************
`define IRHC_EXT_MASK    7
`define IRHC_EXT_RX_HANDSHAKE_SELECT    6
`define IRHC_EXT_RDY     5
`define IRHC_CTRL_EN     7
`define IRHC_CTRL_MST    6
`define IRHC_CTRL_DIR    4
`define IRHC_CTRL_ACK    1
`define IRHC_ST_IFACE    0
`define IRHC_ST_STOP     1
`define IRHC_ST_ERROR_STOP_FLAG     2

// ****************************************
// Reset values and codes
// ****************************************
`define IRHC_EXT_RST     8'h00
`define IRHC_CTRL_RST    8'h00
`define IRHC_MASK_RST    3'h1
`define IRHC_SWITCH_RD   8'h0F
`define IRHC_CLR_CH0     4'h5
`define IRHC_CLR_CH1     4'h6
`define IRHC_CLR_BOTH    4'h7
`define IRHC_DATA_BITS   8

`endif

// >>> src/irhc_pkg.sv
// Types shared by the receive handshake control slice.
// Assumes the constants header is included by each module that needs it.
package irhc_pkg;

   // ****************************************
   // Receiver states, Gray along idle-data-ack
   // ****************************************
   typedef enum logic [1:0] {
      IRHC_IDLE = 2'b00,
      IRHC_DATA = 2'b01,
      IRHC_ACK  = 2'b11
   } irhc_state_t;

endpackage

// >>> src/irhc_sync.sv
// Two-stage synchroniser for pin levels entering the system clock domain.
// Assumes inputs are plain levels; no pulse shorter than two clocks.
`timescale 1ns/1ps

module irhc_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // ****************************************
   // First stage feeds only the second
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '1;
         sync_r <= '1;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule

// >>> src/irhc_rx_shift.sv
// Serial receive shifter: start/stop detection, eight data bits, ninth
// acknowledge clock. Assumes synchronised SCL/SDA levels at the input.
`timescale 1ns/1ps
`include "irhc_params.svh"

module irhc_rx_shift import irhc_pkg::*; #(
   parameter int DATA_BITS = `IRHC_DATA_BITS
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clear,
   input  wire logic       scl_s,
   input  wire logic       sda_s,
   input  wire logic       ack_value,
   output logic            byte_done,
   output logic [7:0]      shift_data,
   output logic            ack_bus,
   output logic            stop_det,
   output logic            err_stop_det,
   output logic            ack_drive
);

   irhc_state_t state_r;
   logic        scl_d_r;
   logic        sda_d_r;
   logic [3:0]  cnt_r;
   logic        ninth_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;

   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // ****************************************
   // Byte framing
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || clear) begin
         state_r      <= IRHC_IDLE;
         cnt_r        <= 4'h0;
         ninth_r      <= 1'b0;
         shift_data   <= 8'h00;
         ack_bus      <= 1'b1;
         ack_drive    <= 1'b0;
         byte_done    <= 1'b0;
         stop_det     <= 1'b0;
         err_stop_det <= 1'b0;
      end else begin
         byte_done    <= 1'b0;
         stop_det     <= 1'b0;
         err_stop_det <= 1'b0;
         if (start_c) begin
            state_r   <= IRHC_DATA;
            cnt_r     <= 4'h0;
            ninth_r   <= 1'b0;
            ack_drive <= 1'b0;
         end else if (stop_c) begin
            // The stop's own SCL rise shifts one bit: still a normal stop
            if (state_r == IRHC_ACK || cnt_r > 4'h1) begin
               err_stop_det <= 1'b1;
            end else begin
               stop_det <= 1'b1;
            end
            state_r   <= IRHC_IDLE;
            cnt_r     <= 4'h0;
            ninth_r   <= 1'b0;
            ack_drive <= 1'b0;
         end else begin
            unique case (state_r)
               IRHC_IDLE: begin
               end
               IRHC_DATA: begin
                  if (scl_rise) begin
                     shift_data <= {shift_data[6:0], sda_s};
                     cnt_r      <= cnt_r + 4'h1;
                     if (cnt_r == 4'(DATA_BITS - 1)) begin
                        state_r <= IRHC_ACK;
                     end
                  end
               end
               IRHC_ACK: begin
                  if (scl_fall && !ninth_r) begin
                     ack_drive <= ~ack_value;
                  end else if (scl_rise) begin
                     ninth_r   <= 1'b1;
                     byte_done <= 1'b1;
                     ack_bus   <= sda_s;
                  end else if (scl_fall && ninth_r) begin
                     ack_drive <= 1'b0;
                     ninth_r   <= 1'b0;
                     cnt_r     <= 4'h0;
                     state_r   <= IRHC_DATA;
                  end
               end
               default: begin
                  state_r <= IRHC_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// >>> tb/irhc_ctrl_assertions.sv
// Concurrent checks for the receive handshake control slice.
// Assumes it is bound to irhc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "irhc_params.svh"

module irhc_ctrl_assertions (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic       irq,
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   logic [7:0] ext_r;
   logic [7:0] ctrl_r;
   logic       rd_dat;

   // Shadow copies of the writable bits; clear codes leave them alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_r  <= 8'h00;
         ctrl_r <= 8'h00;
      end else if (wr_stb && addr == `IRHC_OFS_EXT) begin
         ext_r  <= wr_data;
      end else if (wr_stb && addr == `IRHC_OFS_CTRL) begin
         ctrl_r <= wr_data;
      end
   end
   assign rd_dat = rd_stb && addr == `IRHC_OFS_DATA;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   rd_idle_zero_a: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   pins_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("open-drain output level not zero");
   ext_readback_a: assert property (
      rd_stb && addr == `IRHC_OFS_EXT |=>
      rd_data[7:6] == ext_r[7:6] && rd_data[4:0] == 5'h00)
      else $error("extended control readback wrong");
   switch_read_a: assert property (
      rd_stb && addr == `IRHC_OFS_SWITCH |=> rd_data == 8'h0F)
      else $error("switch register did not read as ones");
   unmapped_read_a: assert property (
      rd_stb && addr[2:1] == 2'b11 |=> rd_data == 8'h00)
      else $error("unmapped index read not zero");
   ctrl_readback_a: assert property (
      rd_stb && addr == `IRHC_OFS_CTRL && !ctrl_r[4] |=>
      rd_data[7] == ctrl_r[7] && rd_data[4] == 1'b0 &&
      rd_data[1] == ctrl_r[1])
      else $error("receive mode ack or enable readback wrong");
   hold_release_a: assert property (
      scl_oe && rd_dat && !ctrl_r[4] |-> ##2 !scl_oe)
      else $error("clock hold not released by data read");
   tx_read_keeps_a: assert property (
      scl_oe && rd_dat && ctrl_r[4] |=> scl_oe [*2])
      else $error("transmit mode read released clock hold");
   mask_quiet_a: assert property (
      wr_stb && addr == `IRHC_OFS_MASK && wr_data[2:0] == 3'h0
      |-> ##2 !irq)
      else $error("interrupt stayed up with all sources masked");
   ack_gate_a: assert property (
      $rose(sda_oe) |-> ctrl_r[7] && !ctrl_r[4] && !ctrl_r[1])
      else $error("acknowledge driven outside enabled receive");

   hold_seen_c: cover property ($rose(scl_oe));
   irq_seen_c: cover property ($rose(irq));
   ack_seen_c: cover property ($rose(sda_oe));
endmodule

// >>> tb/irhc_master_model.sv
// Two-wire bus master model, open drain, 400 ns bit period.
// Assumes pulled-up wires; SCL stands high outside frames.
`timescale 1ns/1ps

module irhc_master_model (
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      scl_low,
   output logic      sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // Slave may stretch the clock; the bench watchdog bounds the wait
   task automatic clk_high();
      scl_low = 1'b0;
      wait (scl_w);
      #200;
   endtask

   task automatic start_cond();
      sda_low = 1'b0;
      #100;
      clk_high();
      sda_low = 1'b1;
      #200;
      scl_low = 1'b1;
      #100;
   endtask

   // Eight bits MSB first, then a ninth clock with SDA released
   task automatic send_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~d[i];
         #100;
         clk_high();
         scl_low = 1'b1;
         #100;
      end
      sda_low = 1'b0;
      #100;
      clk_high();
      scl_low = 1'b1;
      #100;
   endtask

   task automatic stop_cond();
      sda_low = 1'b1;
      #100;
      clk_high();
      sda_low = 1'b0;
      #200;
   endtask
endmodule

// >>> tb/irhc_ctrl_bench.sv
// Self-checking bench for irhc_ctrl with a bus master model on the link.
// Assumes the design's register map header and 20 MHz clock.
`timescale 1ns/1ps
`include "irhc_params.svh"

module irhc_ctrl_bench;
   logic       clk;
   logic       sys_rst;
   logic [2:0] addr;
   logic [7:0] wr_data;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rd_data;
   logic       irq;
   logic       scl_out;
   logic       scl_oe;
   logic       sda_out;
   logic       sda_oe;
   logic       m_scl;
   logic       m_sda;
   logic       scl_w;
   logic       sda_w;
   logic [7:0] tmp;
   int         errors;
   int         cmp_count;
   int         cyc;

   // Pulled-up wires: low while either party pulls
   assign scl_w = !m_scl && (scl_oe ? scl_out : 1'b1);
   assign sda_w = !m_sda && (sda_oe ? sda_out : 1'b1);

   irhc_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .irq(irq), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe));
   irhc_master_model mst_u (.scl_w(scl_w), .sda_w(sda_w),
      .scl_low(m_scl), .sda_low(m_sda));

   always #25 clk = ~clk;

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge clk);
      wr_stb  <= 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rd_data;
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d & m, e);
   endtask

   task automatic rx(input logic [7:0] d);
      mst_u.start_cond();
      mst_u.send_byte(d);
      repeat (10) @(negedge clk);
      chk({7'h0, sda_oe}, 8'h00);
   endtask

   task automatic t_regs();
      rdchk(`IRHC_OFS_EXT, 8'hFF, 8'h00);
      wr(`IRHC_OFS_EXT, 8'hFF);
      rdchk(`IRHC_OFS_EXT, 8'hFF, 8'hC0);
      wr(`IRHC_OFS_EXT, 8'h00);
      rdchk(`IRHC_OFS_SWITCH, 8'hFF, 8'h0F);
      rdchk(3'h7, 8'hFF, 8'h00);
      wr(`IRHC_OFS_CTRL, 8'h90);
      rdchk(`IRHC_OFS_CTRL, 8'h90, 8'h90);
      wr(`IRHC_OFS_CTRL, 8'h02);
      rdchk(`IRHC_OFS_CTRL, 8'h12, 8'h02);
      $display("test regs done");
   endtask

   task automatic t_cont();
      wr(`IRHC_OFS_CTRL, 8'h80);
      rx(8'hA5);
      chk({7'h0, scl_oe}, 8'h00);
      rdchk(`IRHC_OFS_EXT, 8'h20, 8'h20);
      chk({7'h0, irq}, 8'h01);
      rx(8'h3C);
      chk({7'h0, scl_oe}, 8'h01);
      rdchk(`IRHC_OFS_DATA, 8'hFF, 8'hA5);
      repeat (3) @(negedge clk);
      rdchk(`IRHC_OFS_EXT, 8'h20, 8'h20);
      rdchk(`IRHC_OFS_DATA, 8'hFF, 8'h3C);
      rdchk(`IRHC_OFS_EXT, 8'h20, 8'h00);
      mst_u.stop_cond();
      wr(`IRHC_OFS_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h0, irq}, 8'h00);
      wr(`IRHC_OFS_MASK, 8'h01);
      $display("test continuous done");
   endtask

   task automatic t_stop();
      // Third pass runs in master mode, where a stop must stay quiet
      logic [7:0] st_exp [3] = '{8'h03, 8'h02, 8'h02};
      for (int m = 0; m < 3; m++) begin
         wr(`IRHC_OFS_EXT, m == 1 ? 8'h80 : 8'h00);
         wr(`IRHC_OFS_CTRL, m == 2 ? 8'hC0 : 8'h80);
         rx(8'h5A);
         rdchk(`IRHC_OFS_DATA, 8'hFF, 8'h5A);
         wr(`IRHC_OFS_STATUS, 8'h07);
         mst_u.stop_cond();
         repeat (6) @(negedge clk);
         rdchk(`IRHC_OFS_STATUS, 8'h07, st_exp[m]);
         chk({7'h0, irq}, {7'h0, m == 0});
      end
      wr(`IRHC_OFS_CTRL, 8'h80);
      wr(`IRHC_OFS_STATUS, 8'h07);
      $display("test stop done");
   endtask

   task automatic t_rx_handshake_select();
      wr(`IRHC_OFS_EXT, 8'h40);
      rx(8'h96);
      chk({7'h0, scl_oe}, 8'h01);
      wr(`IRHC_OFS_CTRL, 8'h90);
      rd(`IRHC_OFS_DATA, tmp);
      chk({7'h0, scl_oe}, 8'h01);
      rdchk(`IRHC_OFS_EXT, 8'h20, 8'h20);
      wr(`IRHC_OFS_CTRL, 8'h80);
      rdchk(`IRHC_OFS_DATA, 8'hFF, 8'h96);
      repeat (2) @(negedge clk);
      chk({7'h0, scl_oe}, 8'h00);
      mst_u.stop_cond();
      $display("test handshake done");
   endtask

   task automatic t_clear();
      // Code 6 hits the other channel only, so ready must survive it
      logic [7:0] codes [4] = '{8'h06, 8'h05, 8'h07, 8'h00};
      wr(`IRHC_OFS_EXT, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rx(8'hC3);
         if (i == 3)
            wr(`IRHC_OFS_CTRL, 8'h00);
         else
            wr(`IRHC_OFS_SWITCH, codes[i]);
         repeat (2) @(negedge clk);
         rdchk(`IRHC_OFS_EXT, 8'h20, i ? 8'h00 : 8'h20);
         wr(`IRHC_OFS_CTRL, 8'h80);
         if (i == 0)
            rd(`IRHC_OFS_DATA, tmp);
         mst_u.stop_cond();
      end
      $display("test clear done");
   endtask

   initial begin
      clk       = 1'b0;
      sys_rst   = 1'b1;
      addr      = 3'h0;
      wr_data   = 8'h00;
      wr_stb    = 1'b0;
      rd_stb    = 1'b0;
      errors    = 0;
      cmp_count = 0;
      cyc       = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      t_regs();
      t_cont();
      t_stop();
      t_rx_handshake_select();
      t_clear();
      print_verdict();
   end
endmodule

bind irhc_ctrl irhc_ctrl_assertions chk_u (.clk(clk), .sys_rst(sys_rst),
   .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rd_data(rd_data), .irq(irq), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
